// >>> core/scg_pkg.sv
package scg_pkg;
  // ****************************************
  // Control register layout and reset values
  // ****************************************
  localparam logic [7:0] PROC_CLK_RST  = 8'h02;
  localparam logic [7:0] SUBOSC_RST    = 8'h00;
  localparam logic [7:0] CSS_RST       = 8'h00;
  localparam int         MAIN_STOP_POS = 7;
  localparam int         MAIN_RATE_POS = 1;
  localparam int         FB_OFF_POS    = 1;
  localparam int         SUB_STOP_POS  = 0;
  localparam int         CSS_SEL_BIT   = 4;
  localparam int         CSS_STAT_BIT  = 5;

  // ****************************************
  // Divider taps and timing counts
  // ****************************************
  localparam int         DIV_W        = 8;
  localparam int         SLOW_TAP     = 1;
  localparam int         SW_W         = 10;
  localparam int         STAB_W       = 16;
  localparam logic [9:0] SW_MAIN_SLOW = 10'h004;
  localparam logic [9:0] SW_TO_MAIN   = 10'h002;
  localparam int         XT_FAST_SUB  = 306;
  localparam int         XT_SLOW_SUB  = 76;
  localparam int         RC_FAST_SUB  = 244;
  localparam int         RC_SLOW_SUB  = 61;
  localparam int         XT_STAB_EXP  = 15;
  localparam int         RC_STAB_EXP  = 7;
  localparam int         XT_STAB      = 2 ** XT_STAB_EXP;
  localparam int         RC_STAB      = 2 ** RC_STAB_EXP;

  typedef enum logic [1:0] {
    ST_STAB,
    ST_RUN,
    ST_SWITCH,
    ST_STOP
  } scg_state_t;
endpackage

// >>> core/scg_div_if.sv
`timescale 1ns/10ps
interface scg_div_if;
  logic                     main_tick;
  logic                     run;
  logic [scg_pkg::DIV_W-1:0] div_ticks;

  modport ctrl (
    output main_tick,
    output run,
    input  div_ticks
  );
  modport div (
    input  main_tick,
    input  run,
    output div_ticks
  );
endinterface

// >>> core/scg_divider.sv
`timescale 1ns/10ps
module scg_divider (
  input wire logic clk,
  input wire logic reset,
  scg_div_if.div   bus
);
  logic [scg_pkg::DIV_W-1:0] cnt_reg;
  logic                      carry;

  // ****************************************
  // Binary prescaler on the main oscillator
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset || !bus.run) begin
      cnt_reg <= '0;
    end else if (bus.main_tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Tap i pulses once every 2^(i+1) main ticks; a ripple avoids variable part-selects
  always_comb begin
    carry = bus.run && bus.main_tick;
    for (int i = 0; i < scg_pkg::DIV_W; i++) begin
      carry            = carry && cnt_reg[i];
      bus.div_ticks[i] = carry;
    end
  end

  AST_DIV_STOPPED: assert property (@(posedge clk) disable iff (reset)
    !bus.run |-> bus.div_ticks == '0)
    else $error("divider ticks while main oscillator stopped");
endmodule

// >>> core/scg_clock_gen.sv
// Summary of operation
// - Reset selects slow main rate, control 02H
// - Main oscillator stopped while reset held
// - Three CPU rates chosen by two registers
// - Feedback resistor select bit disconnects resistor
// - Sub stop bit halts subsystem oscillator
// - Select bit moves CPU to subsystem clock
// - Main stop bit halts main on subclock
// - Clearing main stop bit restarts main oscillator
// - On main clock, STOP and HALT allowed
// - On subclock, HALT allowed, STOP refused
// - Divider derives CPU and peripheral clocks
// - Subclock feeds only timers, watch, LCD
// - Other peripherals stop with main clock, except externally clocked ones
// - Old clock persists a bounded time
// - Crystal switch limits 4, 2, 306, 76
// - RC switch limits 244, 61, 4, 2
// - Limits counted in old CPU clocks
// - Crystal reset release waits 2^15 periods
// - RC reset release waits 2^7 periods
// - Read-only status shows subclock in use
`timescale 1ns/10ps
module scg_clock_gen #(
  parameter bit          RC_OSC      = 1'b0,
  parameter int unsigned STAB_CYCLES = RC_OSC ? scg_pkg::RC_STAB : scg_pkg::XT_STAB,
  parameter int unsigned SUB_FROM_FAST = RC_OSC ? scg_pkg::RC_FAST_SUB : scg_pkg::XT_FAST_SUB,
  parameter int unsigned SUB_FROM_SLOW = RC_OSC ? scg_pkg::RC_SLOW_SUB : scg_pkg::XT_SLOW_SUB,
  parameter int unsigned NUM_PERIPH  = scg_pkg::DIV_W
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  main_osc_tick,
  input  wire logic                  sub_osc_tick,
  input  wire logic                  ext_clk_tick,
  input  wire logic                  ext_clk_sel,
  input  wire logic                  proc_clk_wr,
  input  wire logic                  subosc_wr,
  input  wire logic                  css_wr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  stop_req,
  input  wire logic                  halt_req,
  input  wire logic                  wake,
  output logic      [7:0]            processor_clock_ctrl,
  output logic      [7:0]            suboscillator_mode_reg,
  output logic      [7:0]            subclock_ctrl,
  output logic                       active_clock_status,
  output logic                       main_osc_enable,
  output logic                       sub_osc_enable,
  output logic                       feedback_resistor_off,
  output logic                       cpu_clk_en,
  output logic                       cpu_ready,
  output logic                       stop_mode,
  output logic                       halt_mode,
  output logic [NUM_PERIPH-1:0]      periph_tick,
  output logic [3:0]                 sub_periph_tick
);
  // ****************************************
  // Declarations
  // ****************************************
  scg_div_if                        dbus ();
  scg_pkg::scg_state_t              state_reg;
  logic                             main_osc_stop_bit;
  logic                             main_rate_select_bit;
  logic                             oscillator_select_bit;
  logic                             sub_stop_reg;
  logic                             fb_off_reg;
  logic                             act_sub_reg;
  logic                             act_rate_reg;
  logic                             sub_half_reg;
  logic [scg_pkg::SW_W-1:0]         sw_cnt_reg;
  logic [scg_pkg::SW_W-1:0]         sw_lim_reg;
  logic [scg_pkg::STAB_W-1:0]       stab_cnt_reg;
  logic                             halt_reg;
  logic                             main_run;
  logic                             old_tick;
  logic                             sub_cpu_tick;
  logic                             req_differs;

  localparam logic [scg_pkg::STAB_W-1:0] STAB_LAST = scg_pkg::STAB_W'(STAB_CYCLES - 1);
  localparam logic [scg_pkg::SW_W-1:0]   LIM_FAST  = scg_pkg::SW_W'(SUB_FROM_FAST);
  localparam logic [scg_pkg::SW_W-1:0]   LIM_SLOW  = scg_pkg::SW_W'(SUB_FROM_SLOW);

  // Tick of the CPU clock for a given selection
  function automatic logic rate_tick(input logic sub, input logic rate,
                                     input logic mtick, input logic stick,
                                     input logic slow);
    if (sub) begin
      rate_tick = stick;
    end else if (rate) begin
      rate_tick = slow;
    end else begin
      rate_tick = mtick;
    end
  endfunction

  // Worst-case switch time in clocks of the selection being left
  function automatic logic [scg_pkg::SW_W-1:0] switch_limit(input logic old_sub,
                                                            input logic old_rate,
                                                            input logic new_sub);
    if (old_sub || (!new_sub && old_rate)) begin
      switch_limit = scg_pkg::SW_TO_MAIN;
    end else if (!new_sub) begin
      switch_limit = scg_pkg::SW_MAIN_SLOW;
    end else if (old_rate) begin
      switch_limit = LIM_SLOW;
    end else begin
      switch_limit = LIM_FAST;
    end
  endfunction

  // ****************************************
  // Oscillator control and divider
  // ****************************************
  // Main stop only bites while the CPU really runs from the subclock
  assign main_run = !reset && state_reg != scg_pkg::ST_STOP
                    && !(main_osc_stop_bit && act_sub_reg);
  assign dbus.main_tick = main_osc_tick;
  assign dbus.run       = main_run;

  scg_divider u_div (
    .clk   (clk),
    .reset (reset),
    .bus   (dbus.div)
  );

  // Subclock CPU rate is half the subsystem oscillator
  always_ff @(posedge clk) begin
    if (reset || sub_stop_reg) begin
      sub_half_reg <= 1'b0;
    end else if (sub_osc_tick) begin
      sub_half_reg <= !sub_half_reg;
    end
  end

  assign sub_cpu_tick = sub_osc_tick && sub_half_reg && !sub_stop_reg;
  assign old_tick     = rate_tick(act_sub_reg, act_rate_reg, main_osc_tick && main_run,
                                  sub_cpu_tick, dbus.div_ticks[scg_pkg::SLOW_TAP]);
  assign req_differs  = (oscillator_select_bit != act_sub_reg)
                        || (!oscillator_select_bit && main_rate_select_bit != act_rate_reg);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      main_osc_stop_bit    <= scg_pkg::PROC_CLK_RST[scg_pkg::MAIN_STOP_POS];
      main_rate_select_bit <= scg_pkg::PROC_CLK_RST[scg_pkg::MAIN_RATE_POS];
    end else if (proc_clk_wr) begin
      main_osc_stop_bit    <= wdata[scg_pkg::MAIN_STOP_POS];
      main_rate_select_bit <= wdata[scg_pkg::MAIN_RATE_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fb_off_reg   <= scg_pkg::SUBOSC_RST[scg_pkg::FB_OFF_POS];
      sub_stop_reg <= scg_pkg::SUBOSC_RST[scg_pkg::SUB_STOP_POS];
    end else if (subosc_wr) begin
      fb_off_reg   <= wdata[scg_pkg::FB_OFF_POS];
      sub_stop_reg <= wdata[scg_pkg::SUB_STOP_POS];
    end
  end

  // Software must only pick the subclock once it oscillates stably
  always_ff @(posedge clk) begin
    if (reset) begin
      oscillator_select_bit <= scg_pkg::CSS_RST[scg_pkg::CSS_SEL_BIT];
    end else if (css_wr) begin
      oscillator_select_bit <= wdata[scg_pkg::CSS_SEL_BIT];
    end
  end

  // ****************************************
  // Sequencer: stabilization, run, switch, stop
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg    <= scg_pkg::ST_STAB;
      stab_cnt_reg <= '0;
      sw_cnt_reg   <= '0;
      sw_lim_reg   <= '0;
      act_sub_reg  <= scg_pkg::CSS_RST[scg_pkg::CSS_SEL_BIT];
      act_rate_reg <= scg_pkg::PROC_CLK_RST[scg_pkg::MAIN_RATE_POS];
    end else begin
      case (state_reg)
        scg_pkg::ST_STAB: begin
          // Only a reset or STOP release gets an automatic wait
          if (main_osc_tick) begin
            if (stab_cnt_reg == STAB_LAST) begin
              state_reg <= scg_pkg::ST_RUN;
            end else begin
              stab_cnt_reg <= stab_cnt_reg + 1'b1;
            end
          end
        end
        scg_pkg::ST_RUN: begin
          if (stop_req && !act_sub_reg && !halt_reg) begin
            state_reg <= scg_pkg::ST_STOP;
          end else if (req_differs) begin
            state_reg  <= scg_pkg::ST_SWITCH;
            sw_cnt_reg <= '0;
            sw_lim_reg <= switch_limit(act_sub_reg, act_rate_reg, oscillator_select_bit);
          end
        end
        scg_pkg::ST_SWITCH: begin
          // Old clock keeps running until the worst-case count elapses
          if (old_tick) begin
            if (sw_cnt_reg + 1'b1 >= sw_lim_reg) begin
              act_sub_reg  <= oscillator_select_bit;
              act_rate_reg <= main_rate_select_bit;
              state_reg    <= scg_pkg::ST_RUN;
            end else begin
              sw_cnt_reg <= sw_cnt_reg + 1'b1;
            end
          end
        end
        scg_pkg::ST_STOP: begin
          if (wake) begin
            state_reg    <= scg_pkg::ST_STAB;
            stab_cnt_reg <= '0;
          end
        end
        default: begin
          state_reg <= scg_pkg::ST_STAB;
        end
      endcase
    end
  end

  // HALT gates only the CPU; allowed on either clock; a request beats a same-cycle wake
  always_ff @(posedge clk) begin
    if (reset) begin
      halt_reg <= 1'b0;
    end else if (halt_req && state_reg == scg_pkg::ST_RUN) begin
      halt_reg <= 1'b1;
    end else if (wake) begin
      halt_reg <= 1'b0;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      processor_clock_ctrl   <= scg_pkg::PROC_CLK_RST;
      suboscillator_mode_reg <= scg_pkg::SUBOSC_RST;
      subclock_ctrl          <= scg_pkg::CSS_RST;
      active_clock_status    <= 1'b0;
    end else begin
      processor_clock_ctrl   <= '0;
      processor_clock_ctrl[scg_pkg::MAIN_STOP_POS] <= main_osc_stop_bit;
      processor_clock_ctrl[scg_pkg::MAIN_RATE_POS] <= main_rate_select_bit;
      suboscillator_mode_reg <= '0;
      suboscillator_mode_reg[scg_pkg::FB_OFF_POS]   <= fb_off_reg;
      suboscillator_mode_reg[scg_pkg::SUB_STOP_POS] <= sub_stop_reg;
      subclock_ctrl          <= '0;
      subclock_ctrl[scg_pkg::CSS_SEL_BIT]  <= oscillator_select_bit;
      subclock_ctrl[scg_pkg::CSS_STAT_BIT] <= act_sub_reg;
      active_clock_status    <= act_sub_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      main_osc_enable       <= 1'b0;
      sub_osc_enable        <= 1'b0;
      feedback_resistor_off <= 1'b0;
    end else begin
      main_osc_enable       <= main_run;
      sub_osc_enable        <= !sub_stop_reg;
      feedback_resistor_off <= fb_off_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_clk_en <= 1'b0;
      cpu_ready  <= 1'b0;
      stop_mode  <= 1'b0;
      halt_mode  <= 1'b0;
    end else begin
      cpu_clk_en <= old_tick && !halt_reg
                    && (state_reg == scg_pkg::ST_RUN || state_reg == scg_pkg::ST_SWITCH);
      cpu_ready  <= state_reg == scg_pkg::ST_RUN || state_reg == scg_pkg::ST_SWITCH;
      stop_mode  <= state_reg == scg_pkg::ST_STOP;
      halt_mode  <= halt_reg;
    end
  end

  // External-clocked peripherals keep counting with main stopped
  always_ff @(posedge clk) begin
    if (reset) begin
      periph_tick     <= '0;
      sub_periph_tick <= '0;
    end else begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        periph_tick[i] <= ext_clk_sel ? ext_clk_tick
                          : dbus.div_ticks[i] && state_reg != scg_pkg::ST_STAB;
      end
      sub_periph_tick <= {4{sub_osc_tick && !sub_stop_reg}};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_RESET_SLOW: assert property (@(posedge clk)
    reset |=> processor_clock_ctrl == scg_pkg::PROC_CLK_RST && !active_clock_status)
    else $error("reset did not select slow main rate");
  AST_RESET_OSC_OFF: assert property (@(posedge clk)
    reset |=> !main_osc_enable)
    else $error("main oscillator enabled during reset");
  AST_FB_OFF_OUT: assert property (@(posedge clk) disable iff (reset)
    subosc_wr |=> ##1 feedback_resistor_off == $past(wdata[scg_pkg::FB_OFF_POS], 2))
    else $error("feedback resistor output does not follow write");
  AST_SUB_STOP: assert property (@(posedge clk) disable iff (reset)
    subosc_wr && wdata[scg_pkg::SUB_STOP_POS] |=> ##1 !sub_osc_enable ##1 sub_periph_tick == '0)
    else $error("subsystem oscillator not stopped");
  AST_MAIN_STOP: assert property (@(posedge clk) disable iff (reset)
    main_osc_stop_bit && act_sub_reg |=> !main_osc_enable)
    else $error("main oscillator runs with stop bit on subclock");
  AST_MAIN_RESTART: assert property (@(posedge clk) disable iff (reset)
    proc_clk_wr && !wdata[scg_pkg::MAIN_STOP_POS] && state_reg != scg_pkg::ST_STOP
    && !stop_req |=> ##1 main_osc_enable)
    else $error("main oscillator did not restart");
  AST_NO_STOP_ON_SUB: assert property (@(posedge clk) disable iff (reset)
    state_reg == scg_pkg::ST_RUN && act_sub_reg |=> state_reg != scg_pkg::ST_STOP)
    else $error("STOP entered on subsystem clock");
  AST_STOP_ON_MAIN: assert property (@(posedge clk) disable iff (reset)
    state_reg == scg_pkg::ST_RUN && !act_sub_reg && stop_req && !halt_reg
    |=> ##1 stop_mode)
    else $error("STOP refused on main clock");
  AST_SWITCH_BOUND: assert property (@(posedge clk) disable iff (reset)
    state_reg == scg_pkg::ST_SWITCH |-> sw_cnt_reg < sw_lim_reg)
    else $error("clock switch exceeded its old-clock limit");
  AST_STATUS_HOLD: assert property (@(posedge clk) disable iff (reset)
    css_wr && state_reg == scg_pkg::ST_RUN |=> $stable(act_sub_reg))
    else $error("status changed on select write");
  AST_STAB_WAIT: assert property (@(posedge clk) disable iff (reset)
    state_reg == scg_pkg::ST_STAB |-> !cpu_ready || $past(state_reg) != scg_pkg::ST_STAB)
    else $error("CPU released during stabilization");
endmodule

// >>> tb/scg_osc_model.sv
`timescale 1ns/10ps
// ****************************************
// Oscillator sources feeding the clock generator
// ****************************************
module scg_osc_model #(
  parameter int MAIN_DIV = 2,
  parameter int SUB_DIV  = 16
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic main_en,
  input  wire logic sub_en,
  output logic      main_tick,
  output logic      sub_tick
);
  int main_cnt_reg;
  int sub_cnt_reg;

  // A stopped oscillator gives no edges at all, so the counters clear to zero too
  always_ff @(posedge clk) begin
    if (reset || !main_en) begin
      main_cnt_reg <= 0;
      main_tick    <= 1'b0;
    end else begin
      main_cnt_reg <= (main_cnt_reg == MAIN_DIV - 1) ? 0 : main_cnt_reg + 1;
      main_tick    <= (main_cnt_reg == MAIN_DIV - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !sub_en) begin
      sub_cnt_reg <= 0;
      sub_tick    <= 1'b0;
    end else begin
      sub_cnt_reg <= (sub_cnt_reg == SUB_DIV - 1) ? 0 : sub_cnt_reg + 1;
      sub_tick    <= (sub_cnt_reg == SUB_DIV - 1);
    end
  end
endmodule

// >>> tb/system_clock_generator_tb.sv
`timescale 1ns/10ps
module system_clock_generator_tb;
  logic       clk;
  logic       reset;
  logic       main_tick;
  logic       sub_tick;
  logic       ext_clk_tick;
  logic       ext_clk_sel;
  logic       proc_clk_wr;
  logic       subosc_wr;
  logic       css_wr;
  logic [7:0] wdata;
  logic       stop_req;
  logic       halt_req;
  logic       wake;
  logic [7:0] proc_clk_q;
  logic [7:0] subosc_q;
  logic [7:0] css_q;
  logic       status;
  logic       main_en;
  logic       sub_en;
  logic       fb_off;
  logic       cpu_clk_en;
  logic       cpu_ready;
  logic       stop_mode;
  logic       halt_mode;
  logic [7:0] periph_tick;
  logic [3:0] sub_periph_tick;
  int         err_count;
  int         checks;
  int         cycles;

  scg_clock_gen #(.STAB_CYCLES(8)) i_dut (
    .clk(clk), .reset(reset), .main_osc_tick(main_tick), .sub_osc_tick(sub_tick),
    .ext_clk_tick(ext_clk_tick), .ext_clk_sel(ext_clk_sel), .proc_clk_wr(proc_clk_wr),
    .subosc_wr(subosc_wr), .css_wr(css_wr), .wdata(wdata), .stop_req(stop_req),
    .halt_req(halt_req), .wake(wake), .processor_clock_ctrl(proc_clk_q),
    .suboscillator_mode_reg(subosc_q), .subclock_ctrl(css_q), .active_clock_status(status),
    .main_osc_enable(main_en), .sub_osc_enable(sub_en), .feedback_resistor_off(fb_off),
    .cpu_clk_en(cpu_clk_en), .cpu_ready(cpu_ready), .stop_mode(stop_mode),
    .halt_mode(halt_mode), .periph_tick(periph_tick), .sub_periph_tick(sub_periph_tick)
  );

  scg_osc_model i_osc (
    .clk(clk), .reset(reset), .main_en(main_en), .sub_en(sub_en),
    .main_tick(main_tick), .sub_tick(sub_tick)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic stop_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // Register write strobe; outputs settle one edge after it is taken
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    proc_clk_wr = (sel == 0);
    subosc_wr = (sel == 1);
    css_wr = (sel == 2);
    wdata = d;
    @(posedge clk);
    #1;
    proc_clk_wr = 1'b0;
    subosc_wr = 1'b0;
    css_wr = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int sel);
    @(posedge clk);
    #1;
    stop_req = (sel == 0);
    halt_req = (sel == 1);
    wake = (sel == 2);
    @(posedge clk);
    #1;
    stop_req = 1'b0;
    halt_req = 1'b0;
    wake = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_until(input int sel, input logic v, input int lim);
    int   n;
    logic s;
    n = 0;
    s = (sel == 0) ? cpu_ready : status;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
      s = (sel == 0) ? cpu_ready : status;
    end
    chk({7'h00, s}, {7'h00, v});
  endtask

  task automatic count_ticks(input int n, output int c0, output int c1, output int cs,
                             output int ce);
    c0 = 0;
    c1 = 0;
    cs = 0;
    ce = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      c0 += int'(periph_tick[0] === 1'b1);
      c1 += int'(periph_tick[1] === 1'b1);
      cs += int'(sub_periph_tick[0] === 1'b1);
      ce += int'(cpu_clk_en === 1'b1);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(proc_clk_q, 8'h02);
    chk(subosc_q, 8'h00);
    chk(css_q, 8'h00);
    chk({7'h00, main_en}, 8'h00);
    reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, cpu_ready}, 8'h00);
    wait_until(0, 1'b1, 200);
  endtask

  task automatic t_regs_divider;
    int c0;
    int c1;
    int cs;
    int ce;
    count_ticks(80, c0, c1, cs, ce);
    // Main tick every 2 cycles: tap 0 one per 4, tap 1 and slow CPU rate one per 8
    chk(8'(c0 >= 19 && c0 <= 21), 8'h01);
    chk(8'(c1 >= 9 && c1 <= 11), 8'h01);
    chk(8'(ce >= 9 && ce <= 11), 8'h01);
    wr(1, 8'hff);
    chk(subosc_q, 8'h03);
    chk({6'h00, fb_off, sub_en}, 8'h02);
    wr(1, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk({6'h00, fb_off, sub_en}, 8'h01);
  endtask

  task automatic t_sub_path;
    int c0;
    int c1;
    int cs;
    int ce;
    wr(0, 8'h00);
    chk(proc_clk_q, 8'h00);
    // Let the slow-to-fast switch finish so the next one leaves the fast rate
    repeat (20) @(posedge clk);
    #1;
    // Subclock has been running since its restart in t_regs_divider, so it is already stable
    wr(2, 8'h10);
    chk(css_q, 8'h10);
    // 306 fast CPU clocks, one per main tick, one main tick every 2 cycles
    repeat (600) @(posedge clk);
    #1;
    chk({7'h00, status}, 8'h00);
    wait_until(1, 1'b1, 20);
    chk(css_q, 8'h30);
    pulse(0);
    chk({7'h00, stop_mode}, 8'h00);
    pulse(1);
    chk({7'h00, halt_mode}, 8'h01);
    pulse(2);
    chk({7'h00, halt_mode}, 8'h00);
    wr(0, 8'h80);
    chk({7'h00, main_en}, 8'h00);
    count_ticks(100, c0, c1, cs, ce);
    chk(8'(c0), 8'h00);
    chk(8'(cs >= 5), 8'h01);
    chk(8'(ce >= 3 && ce <= 4), 8'h01);
    // Externally clocked peripherals keep counting with main stopped
    ext_clk_sel = 1'b1;
    ext_clk_tick = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(periph_tick, 8'hff);
    ext_clk_sel = 1'b0;
    ext_clk_tick = 1'b0;
    wr(0, 8'h02);
    chk({7'h00, main_en}, 8'h01);
    // No automatic wait here: software lets the oscillator settle first
    repeat (50) @(posedge clk);
    wr(2, 8'h00);
    wait_until(1, 1'b0, 500);
    chk(css_q, 8'h00);
  endtask

  task automatic t_standby_main;
    pulse(1);
    chk({7'h00, halt_mode}, 8'h01);
    pulse(2);
    chk({7'h00, halt_mode}, 8'h00);
    pulse(0);
    chk({6'h00, stop_mode, main_en}, 8'h02);
    pulse(2);
    chk({7'h00, stop_mode}, 8'h00);
    wait_until(0, 1'b1, 200);
  endtask

  initial begin
    err_count = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    ext_clk_tick = 1'b0;
    ext_clk_sel = 1'b0;
    proc_clk_wr = 1'b0;
    subosc_wr = 1'b0;
    css_wr = 1'b0;
    wdata = 8'h00;
    stop_req = 1'b0;
    halt_req = 1'b0;
    wake = 1'b0;
    t_reset();
    t_regs_divider();
    t_sub_path();
    t_standby_main();
    stop_test();
  end
endmodule
